// ---- csitx_peer.sv ----
// Behavioural serial peer that clocks frames into the block as its master
`timescale 1ns/10ps
module csitx_peer (
   // Serial lines
   output logic sck,
   output logic si,
   input wire logic so,
   // Captured word
   output logic [15:0] got
);
   initial begin
      sck = 1'b0;
      si = 1'b0;
      got = 16'h0000;
   end
   // ***********************
   // One frame, MSB first, clock idle low outside frames
   // ***********************
   task automatic frame(input logic [15:0] d, input int n);
      int i;
      si = d[n-1];
      for (i = n - 1; i >= 0; i--) begin
         #80;
         sck = 1'b1;
         got = {got[14:0], so};
         #80;
         sck = 1'b0;
         si = (i > 0) ? d[i-1] : ~d[0];
      end
   endtask
endmodule

// ---- csitx_pkg.sv ----
// Constants, register map and types of the serial transmit buffer block
package csitx_pkg;
   // ***********************
   // Geometry
   // ***********************
   localparam int CSITX_CH = 2;
   localparam int CSITX_AW = 16;
   localparam int CSITX_DW = 16;
   localparam int CSITX_CW = 4;

   // ***********************
   // Register indices (byte address is four times the index)
   // ***********************
   localparam logic [31:0] CSITX_CTRL_IDX0 = 32'hfffff900;
   localparam logic [31:0] CSITX_TXW_IDX0 = 32'hfffff904;
   localparam logic [31:0] CSITX_TXB_IDX0 = 32'hfffff904;
   localparam logic [31:0] CSITX_RXM_IDX0 = 32'hfffff906;
   localparam logic [31:0] CSITX_INITW_IDX0 = 32'hfffff908;
   localparam logic [31:0] CSITX_INITB_IDX0 = 32'hfffff908;
   localparam logic [31:0] CSITX_CTRL_IDX1 = 32'hfffff910;
   localparam logic [31:0] CSITX_TXW_IDX1 = 32'hfffff914;
   localparam logic [31:0] CSITX_TXB_IDX1 = 32'hfffff914;
   localparam logic [31:0] CSITX_RXM_IDX1 = 32'hfffff916;
   localparam logic [31:0] CSITX_INITW_IDX1 = 32'hfffff918;
   localparam logic [31:0] CSITX_INITB_IDX1 = 32'hfffff918;
   localparam logic [31:0] CSITX_IST_IDX = 32'hfffff920;
   localparam logic [31:0] CSITX_IEN_IDX = 32'hfffff921;
   localparam logic [31:0] CSITX_ICLR_IDX = 32'hfffff922;

   // ***********************
   // Control register fields
   // ***********************
   localparam int CSITX_EN_BIT = 7;
   localparam int CSITX_DIR_BIT = 6;
   localparam int CSITX_LEN_BIT = 5;
   localparam int CSITX_REP_BIT = 4;
   localparam int CSITX_BUSY_BIT = 0;

   // ***********************
   // Reset values and last-bit counts
   // ***********************
   localparam logic [15:0] CSITX_WORD_RST = 16'h0000;
   localparam logic [7:0] CSITX_BYTE_RST = 8'h00;
   localparam logic [3:0] CSITX_LAST16 = 4'hf;
   localparam logic [3:0] CSITX_LAST8 = 4'h7;

   // ***********************
   // Types
   // ***********************
   typedef enum logic [2:0] {
      CSITX_SEL_NONE = 3'b000,
      CSITX_SEL_CTRL = 3'b001,
      CSITX_SEL_TXW = 3'b010,
      CSITX_SEL_RXM = 3'b011,
      CSITX_SEL_INIT = 3'b100,
      CSITX_SEL_IST = 3'b101,
      CSITX_SEL_IEN = 3'b110,
      CSITX_SEL_ICLR = 3'b111
   } csitx_sel_e;

   typedef enum logic {
      CSITX_IDLE = 1'b0,
      CSITX_SHIFT = 1'b1
   } csitx_state_e;

   typedef struct packed {
      logic ch;
      csitx_sel_e sel;
   } csitx_dec_s;

   function automatic logic [CSITX_AW-1:0] csitx_addr(input logic [31:0] idx);
      csitx_addr = {idx[CSITX_AW-3:0], 2'b00};
   endfunction
endpackage

// ---- csitx_regs.sv ----
// Transmit and receive-mirror buffer registers of a two-channel serial port
// Behaviour
// - Each channel has a read-only 8-bit receive mirror, byte readable.
// - Mirror equals low receive byte; reading it starts no reception.
// - Mirror clears on reset and when channel enable is cleared.
// - 16-bit transmit word buffer; write starts transfer when direction is 1.
// - Transmit word buffer is accessed in 16-bit units only.
// - Transmit byte buffer aliases the word buffer's low byte.
// - Writing the byte buffer starts transfer when direction is 1.
// - Initial-transmit word holds first repeat data; write starts nothing.
// - Initial byte aliases initial word low byte; write starts nothing.
// - Transfer-in-progress flag goes to 1 when a transfer starts.
// - On completion raise interrupt, clear in-progress flag, wait; in repeat mode the code starts a reserved word at once.
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
module csitx_regs (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [csitx_pkg::CSITX_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Serial pins, one bit per channel
   input wire logic [1:0] sck_in,
   input wire logic [1:0] si_in,
   output logic [1:0] so_out,
   // Interrupt
   output logic irq
);
   import csitx_pkg::*;

   // ***********************
   // Address decode
   // ***********************
   function automatic csitx_dec_s decode(input logic [CSITX_AW-1:0] a);
      csitx_dec_s d;
      d.ch = 1'b0;
      d.sel = CSITX_SEL_NONE;
      if (a == csitx_addr(CSITX_CTRL_IDX0)) d.sel = CSITX_SEL_CTRL;
      if (a == csitx_addr(CSITX_TXW_IDX0)) d.sel = CSITX_SEL_TXW;
      if (a == csitx_addr(CSITX_RXM_IDX0)) d.sel = CSITX_SEL_RXM;
      if (a == csitx_addr(CSITX_INITW_IDX0)) d.sel = CSITX_SEL_INIT;
      if (a == csitx_addr(CSITX_IST_IDX)) d.sel = CSITX_SEL_IST;
      if (a == csitx_addr(CSITX_IEN_IDX)) d.sel = CSITX_SEL_IEN;
      if (a == csitx_addr(CSITX_ICLR_IDX)) d.sel = CSITX_SEL_ICLR;
      if (a == csitx_addr(CSITX_CTRL_IDX1)) begin
         d.sel = CSITX_SEL_CTRL;
         d.ch = 1'b1;
      end
      if (a == csitx_addr(CSITX_TXW_IDX1)) begin
         d.sel = CSITX_SEL_TXW;
         d.ch = 1'b1;
      end
      if (a == csitx_addr(CSITX_RXM_IDX1)) begin
         d.sel = CSITX_SEL_RXM;
         d.ch = 1'b1;
      end
      if (a == csitx_addr(CSITX_INITW_IDX1)) begin
         d.sel = CSITX_SEL_INIT;
         d.ch = 1'b1;
      end
      return d;
   endfunction

   // Merges a word or low-byte write into a 16-bit buffer
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] st);
      if (st[1:0] == 2'b11) begin
         merge = wd[15:0];
      end else begin
         merge = {old[15:8], wd[7:0]};
      end
   endfunction

   // ***********************
   // State
   // ***********************
   logic [15:0] tx_word [CSITX_CH];
   logic [15:0] next_tx_word [CSITX_CH];
   logic [15:0] init_word [CSITX_CH];
   logic [15:0] next_init_word [CSITX_CH];
   logic [15:0] rx_low_buffer [CSITX_CH];
   logic [15:0] start_data [CSITX_CH];
   logic [1:0] enable, next_enable;
   logic [1:0] direction, next_direction;
   logic [1:0] len16, next_len16;
   logic [1:0] repeat_mode, next_repeat_mode;
   logic [1:0] pending, next_pending;
   logic [1:0] ist, next_ist;
   logic [1:0] ien, next_ien;
   logic [1:0] busy, done, start;
   logic [31:0] next_prdata;
   logic next_pslverr;
   csitx_dec_s dec;
   logic setup, wacc, err;
   logic [1:0] clr_bits;

   assign dec = decode(paddr);
   assign setup = psel & ~penable;
   assign wacc = psel & penable & pwrite & ~pslverr;
   assign pready = 1'b1;
   assign irq = |(ist & ien);

   // ***********************
   // Bus answer, captured in the setup cycle
   // ***********************
   always_comb begin
      err = 1'b0;
      if (dec.sel == CSITX_SEL_NONE) err = 1'b1;
      if (pwrite) begin
         if (dec.sel == CSITX_SEL_RXM || dec.sel == CSITX_SEL_IST) begin
            err = 1'b1;
         end
         if ((dec.sel == CSITX_SEL_TXW || dec.sel == CSITX_SEL_INIT) &&
             pstrb[1:0] != 2'b11 && pstrb[1:0] != 2'b01) begin
            err = 1'b1;
         end
      end
      next_prdata = 32'h0000_0000;
      unique case (dec.sel)
         CSITX_SEL_CTRL: begin
            next_prdata[CSITX_EN_BIT] = enable[dec.ch];
            next_prdata[CSITX_DIR_BIT] = direction[dec.ch];
            next_prdata[CSITX_LEN_BIT] = len16[dec.ch];
            next_prdata[CSITX_REP_BIT] = repeat_mode[dec.ch];
            next_prdata[CSITX_BUSY_BIT] = busy[dec.ch];
         end
         CSITX_SEL_TXW: next_prdata[15:0] = tx_word[dec.ch];
         CSITX_SEL_RXM: begin
            next_prdata[7:0] = rx_low_buffer[dec.ch][7:0];
         end
         CSITX_SEL_INIT: next_prdata[15:0] = init_word[dec.ch];
         CSITX_SEL_IST: next_prdata[1:0] = ist;
         CSITX_SEL_IEN: next_prdata[1:0] = ien;
         CSITX_SEL_NONE, CSITX_SEL_ICLR: next_prdata = 32'h0000_0000;
      endcase
      next_pslverr = pslverr;
      if (setup) begin
         next_pslverr = err;
      end
      if (!setup || pwrite) begin
         next_prdata = prdata;
      end
   end

   // ***********************
   // Register writes and transfer starts
   // ***********************
   always_comb begin
      next_enable = enable;
      next_direction = direction;
      next_len16 = len16;
      next_repeat_mode = repeat_mode;
      next_pending = pending;
      next_ien = ien;
      clr_bits = 2'b00;
      start = 2'b00;
      for (int c = 0; c < CSITX_CH; c++) begin
         next_tx_word[c] = tx_word[c];
         next_init_word[c] = init_word[c];
         start_data[c] = tx_word[c];
         // Reserved second word follows the finished one
         if (done[c] && pending[c]) begin
            start[c] = 1'b1;
            next_pending[c] = 1'b0;
         end
         if (wacc && dec.ch == 1'(c)) begin
            if (dec.sel == CSITX_SEL_CTRL && pstrb[0]) begin
               next_enable[c] = pwdata[CSITX_EN_BIT];
               next_direction[c] = pwdata[CSITX_DIR_BIT];
               next_len16[c] = pwdata[CSITX_LEN_BIT];
               next_repeat_mode[c] = pwdata[CSITX_REP_BIT];
            end
            if (dec.sel == CSITX_SEL_INIT) begin
               // Loading the first word never starts a transfer
               next_init_word[c] = merge(init_word[c], pwdata, pstrb);
            end
            if (dec.sel == CSITX_SEL_TXW) begin
               next_tx_word[c] = merge(tx_word[c], pwdata, pstrb);
               if (enable[c] && direction[c]) begin
                  if (busy[c] || start[c]) begin
                     if (repeat_mode[c]) next_pending[c] = 1'b1;
                  end else begin
                     start[c] = 1'b1;
                     if (repeat_mode[c]) begin
                        start_data[c] = init_word[c];
                        next_pending[c] = 1'b1;
                     end else begin
                        start_data[c] = next_tx_word[c];
                     end
                  end
               end
            end
         end
         if (!enable[c]) begin
            next_pending[c] = 1'b0;
         end
      end
      if (wacc && dec.sel == CSITX_SEL_IEN) next_ien = pwdata[1:0];
      if (wacc && dec.sel == CSITX_SEL_ICLR) clr_bits = pwdata[1:0];
      // A completion in the clearing cycle is kept
      next_ist = (ist & ~clr_bits) | done;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < CSITX_CH; c++) begin
            tx_word[c] <= CSITX_WORD_RST;
            init_word[c] <= CSITX_WORD_RST;
         end
         enable <= 2'b00;
         direction <= 2'b00;
         len16 <= 2'b00;
         repeat_mode <= 2'b00;
         pending <= 2'b00;
         ist <= 2'b00;
         ien <= 2'b00;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         for (int c = 0; c < CSITX_CH; c++) begin
            tx_word[c] <= next_tx_word[c];
            init_word[c] <= next_init_word[c];
         end
         enable <= next_enable;
         direction <= next_direction;
         len16 <= next_len16;
         repeat_mode <= next_repeat_mode;
         pending <= next_pending;
         ist <= next_ist;
         ien <= next_ien;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // ***********************
   // Shift engines
   // ***********************
   for (genvar g = 0; g < CSITX_CH; g++) begin : g_ch
      // Receive data clears with reset or channel disable
      csitx_shift u_shift (
         .clk(pclk),
         .rst_n(presetn),
         .clk_en(clk_en),
         .enable(enable[g]),
         .len16(len16[g]),
         .start(start[g]),
         .tx_data(start_data[g]),
         .sck_in(sck_in[g]),
         .si_in(si_in[g]),
         .so_out(so_out[g]),
         .busy(busy[g]),
         .done(done[g]),
         .rx_data(rx_low_buffer[g])
      );
   end
endmodule

// ---- csitx_regs_properties.sv ----
// Checker of bus and serial-line relations of the transmit buffer block
`timescale 1ns/10ps
module csitx_regs_properties (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Serial and interrupt
   input wire logic [1:0] sck_in,
   input wire logic [1:0] so_out,
   input wire logic irq
);
   import csitx_pkg::*;
   logic acc, rxm, txa;
   logic [1:0] sck_q;
   logic [3:0] quiet, next_quiet;
   assign acc = psel && penable && pwrite;
   assign rxm = paddr == 16'he418 || paddr == 16'he458;
   assign txa = paddr[5:0] == 6'h10 || paddr[5:0] == 6'h20;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ***********************
   // Cycles since the last serial clock edge or register write
   // ***********************
   always_comb begin
      next_quiet = quiet;
      if (acc || sck_in != sck_q) next_quiet = 4'h0;
      else if (quiet != 4'hf) next_quiet = quiet + 4'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet <= 4'h0;
         sck_q <= 2'h0;
      end else begin
         quiet <= next_quiet;
         sck_q <= sck_in;
      end
   end
   // ***********************
   // Assertions
   // ***********************
   chk_ready_high: assert property (pready)
      else $error("ready low");
   chk_read_holds: assert property (psel && penable && !pwrite |=>
      prdata == $past(prdata))
      else $error("read data moved after access");
   chk_mirror_ro: assert property (acc && rxm |-> pslverr)
      else $error("write to receive mirror not refused");
   chk_upper_lane: assert property (acc && txa && paddr[15:8] == 8'he4
      && pstrb[1:0] == 2'b10 |-> pslverr)
      else $error("upper byte only write not refused");
   chk_byte_alias: assert property (acc && txa && paddr[15:8] == 8'he4
      && pstrb[1:0] == 2'b01 |-> !pslverr)
      else $error("low byte write refused");
   chk_unmapped_err: assert property (psel && penable
      && paddr == 16'he4fc |-> pslverr)
      else $error("unmapped access not refused");
   chk_irq_masked: assert property (acc && paddr == 16'he484
      && pwdata[1:0] == 2'b00 && !pslverr |=> !irq)
      else $error("interrupt with all enables off");
   chk_dis_clears: assert property (acc && paddr == 16'he400
      && !pwdata[7] |-> ##[1:2] so_out[0] == 1'b0)
      else $error("disabled channel still drives data");
   chk_so_cause: assert property ($changed(so_out)
      |-> quiet <= 4'h6)
      else $error("serial data moved without cause");
   cover property (acc && paddr == 16'he410 && pstrb == 4'h1);
   cover property ($rose(irq));
   cover property ($fell(so_out[1]));
endmodule

bind csitx_regs csitx_regs_properties i_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .sck_in(sck_in), .so_out(so_out), .irq(irq));

// ---- csitx_regs_tb.sv ----
// Self-checking bench of the transmit buffer block
`timescale 1ns/10ps
module csitx_regs_tb;
   import csitx_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
   logic [15:0] paddr, got0, got1;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0] pstrb;
   logic [1:0] so_out;
   wire [1:0] sck_in, si_in;
   int bad_count, checked;
   localparam logic [15:0] C0 = 16'he400, T0 = 16'he410, R0 = 16'he418;
   localparam logic [15:0] I0 = 16'he420, C1 = 16'he440, T1 = 16'he450;
   localparam logic [15:0] R1 = 16'he458, I1 = 16'he460, IST = 16'he480;
   localparam logic [15:0] IEN = 16'he484, ICL = 16'he488;
   csitx_regs i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .sck_in(sck_in), .si_in(si_in), .so_out(so_out),
      .irq(irq));
   csitx_peer i_peer0 (.sck(sck_in[0]), .si(si_in[0]), .so(so_out[0]),
      .got(got0));
   csitx_peer i_peer1 (.sck(sck_in[1]), .si(si_in[1]), .so(so_out[1]),
      .got(got1));
   // ***********************
   // Helpers
   // ***********************
   task automatic check(input string nm, input logic [31:0] seen,
         input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
         bad_count++;
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic xfer(input logic [15:0] a, input logic w,
         input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         results();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the access edge settle before callers look at outputs
      @(negedge pclk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d,
         input logic [3:0] s);
      xfer(a, 1'b1, d, s);
   endtask
   task automatic rc(input string nm, input logic [15:0] a,
         input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0, 4'hf);
      check(nm, rdat, exp);
   endtask
   task automatic wait_ist(input logic [31:0] m);
      int n;
      n = 0;
      do begin
         xfer(IST, 1'b0, 32'h0, 4'hf);
         n++;
      end while ((rdat & m) !== m && n < 100);
      if (n >= 100) begin
         bad_count++;
         results();
      end
   endtask
   // ***********************
   // Scenarios
   // ***********************
   task automatic t_reset();
      logic [15:0] regs [7] = '{T0, R0, I0, T1, R1, I1, IST};
      foreach (regs[i]) rc("reset value", regs[i], 32'h0);
      wr(R0, 32'h55, 4'h1);
      check("mirror write error", rerr, 1'b1);
      rc("mirror after write", R0, 32'h0);
      wr(IST, 32'h3, 4'h1);
      check("status write error", rerr, 1'b1);
      rc("unmapped read", 16'he4fc, 32'h0);
      check("unmapped error", rerr, 1'b1);
   endtask
   task automatic t_alias();
      wr(C0, 32'ha0, 4'h1);
      wr(T0, 32'hbeef, 4'h3);
      rc("no start when direction 0", C0, 32'ha0);
      wr(C0, 32'h80, 4'h1);
      wr(T0, 32'h5a, 4'h1);
      wr(T0, 32'h1100, 4'h2);
      check("upper lane error", rerr, 1'b1);
      wr(I0, 32'h77, 4'h1);
      wr(C0, 32'ha0, 4'h1);
      rc("byte alias", T0, 32'hbe5a);
      wr(I0, 32'h1234, 4'h3);
      wr(C0, 32'he0, 4'h1);
      wr(I0, 32'h4321, 4'h3);
      rc("initial write starts nothing", C0, 32'he0);
      wr(C0, 32'hc0, 4'h1);
      wr(I0, 32'h99, 4'h1);
      rc("initial byte alias", I0, 32'h4399);
   endtask
   task automatic t_single8();
      wr(IEN, 32'h1, 4'h1);
      wr(T0, 32'ha5, 4'h1);
      rc("busy after start", C0, 32'hc1);
      i_peer0.frame(16'h003c, 8);
      wait_ist(32'h1);
      check("irq raised", irq, 1'b1);
      check("byte sent", got0[7:0], 8'ha5);
      rc("idle after done", C0, 32'hc0);
      rc("mirror", R0, 32'h3c);
      rc("mirror read starts nothing", C0, 32'hc0);
      wr(ICL, 32'h1, 4'h1);
      rc("status cleared", IST, 32'h0);
      check("irq cleared", irq, 1'b0);
      wr(C0, 32'h00, 4'h1);
      rc("mirror cleared by disable", R0, 32'h0);
   endtask
   task automatic t_repeat16();
      wr(IEN, 32'h0, 4'h1);
      wr(C1, 32'hf0, 4'h1);
      wr(I1, 32'h8001, 4'h3);
      rc("initial load idle", C1, 32'hf0);
      wr(T1, 32'h7ffe, 4'h3);
      i_peer1.frame(16'h1234, 16);
      wait_ist(32'h2);
      check("masked irq", irq, 1'b0);
      check("first word", got1, 16'h8001);
      rc("second started", C1, 32'hf1);
      wr(ICL, 32'h2, 4'h1);
      i_peer1.frame(16'h4321, 16);
      wait_ist(32'h2);
      check("second word", got1, 16'h7ffe);
      wr(IEN, 32'h2, 4'h1);
      check("irq enabled", irq, 1'b1);
      wr(C1, 32'hd0, 4'h1);
      rc("mirror low byte", R1, 32'h21);
   endtask
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      bad_count = 0;
      checked = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_alias();
      t_single8();
      t_repeat16();
      results();
   end
endmodule

// ---- csitx_shift.sv ----
// Per-channel serial shift engine that samples an external serial clock on the system clock
`timescale 1ns/10ps
module csitx_shift (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Control
   input wire logic enable,
   input wire logic len16,
   input wire logic start,
   input wire logic [csitx_pkg::CSITX_DW-1:0] tx_data,
   // Serial pins
   input wire logic sck_in,
   input wire logic si_in,
   output logic so_out,
   // Status
   output logic busy,
   output logic done,
   output logic [csitx_pkg::CSITX_DW-1:0] rx_data
);
   import csitx_pkg::*;

   csitx_state_e state, next_state;
   logic sck_m, sck_s, sck_d, si_m, si_s;
   logic [CSITX_DW-1:0] shreg, next_shreg, rxsh, next_rxsh;
   logic [CSITX_DW-1:0] next_rx_data;
   logic [CSITX_CW-1:0] cnt, next_cnt;
   logic next_done, rise, fall;
   logic [CSITX_CW-1:0] last;

   assign rise = sck_s & ~sck_d;
   assign fall = ~sck_s & sck_d;
   assign last = len16 ? CSITX_LAST16 : CSITX_LAST8;
   assign busy = (state == CSITX_SHIFT);
   assign so_out = shreg[CSITX_DW-1];

   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_rxsh = rxsh;
      next_rx_data = rx_data;
      next_cnt = cnt;
      next_done = 1'b0;
      if (!enable) begin
         // Disabling the channel clears the receive data
         next_state = CSITX_IDLE;
         next_shreg = CSITX_WORD_RST;
         next_rxsh = CSITX_WORD_RST;
         next_rx_data = CSITX_WORD_RST;
         next_cnt = '0;
      end else begin
         unique case (state)
            CSITX_IDLE: begin
               if (start) begin
                  next_state = CSITX_SHIFT;
                  next_shreg = len16 ? tx_data : {tx_data[7:0], 8'h00};
                  next_rxsh = CSITX_WORD_RST;
                  next_cnt = '0;
               end
            end
            CSITX_SHIFT: begin
               if (fall && cnt != '0) begin
                  next_shreg = {shreg[CSITX_DW-2:0], 1'b0};
               end
               if (rise) begin
                  next_rxsh = {rxsh[CSITX_DW-2:0], si_s};
                  next_cnt = CSITX_CW'(cnt + 4'h1);
                  if (cnt == last) begin
                     next_state = CSITX_IDLE;
                     next_rx_data = {rxsh[CSITX_DW-2:0], si_s};
                     next_done = 1'b1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= CSITX_IDLE;
         shreg <= CSITX_WORD_RST;
         rxsh <= CSITX_WORD_RST;
         rx_data <= CSITX_WORD_RST;
         cnt <= '0;
         done <= 1'b0;
         sck_m <= 1'b0;
         sck_s <= 1'b0;
         sck_d <= 1'b0;
         si_m <= 1'b0;
         si_s <= 1'b0;
      end else if (clk_en) begin
         state <= next_state;
         shreg <= next_shreg;
         rxsh <= next_rxsh;
         rx_data <= next_rx_data;
         cnt <= next_cnt;
         done <= next_done;
         sck_m <= sck_in;
         sck_s <= sck_m;
         sck_d <= sck_s;
         si_m <= si_in;
         si_s <= si_m;
      end
   end
endmodule
